// >>> hw/scsi_intmask_bus_shadow_id_regs.sv
// scsi interrupt masks, bus access, shadow address, target and selector id
//
// Implementation choice: the AHB-Lite interface to the registers.
module scsi_intmask_bus_shadow_id_regs (
   // clock and reset
   input  wire logic                                clk,
   input  wire logic                                rst,
   // ahb-lite slave
   input  wire logic                                hsel,
   input  wire logic [31:0]                         haddr,
   input  wire logic [1:0]                          htrans,
   input  wire logic                                hwrite,
   input  wire logic [2:0]                          hsize,
   input  wire logic [31:0]                         hwdata,
   input  wire logic                                hready,
   output logic      [31:0]                         hrdata,
   output logic                                     hreadyout,
   output logic                                     hresp,
   // scsi bus and events
   input  wire logic [15:0]                         scsi_data_lines,
   input  wire logic [7:0]                          scsi_status_first,
   input  wire scsi_regs_pkg::scsi_status_second_s  scsi_status_second,
   input  wire logic                                parity_latch_clear,
   input  wire scsi_regs_pkg::selection_event_s     selection_event,
   // dma preload
   input  wire logic                                preload_load,
   input  wire logic [63:0]                         preload_value,
   // outputs
   output logic      [15:0]                         scsi_output_data_pair,
   output logic      [3:0]                          own_id_field,
   output logic                                     module_interrupt,
   output logic                                     interrupt_a_pin_n,
   output logic                                     software_tick
);

   ////////////////////////////////////////////////////////////////////////
   // register state

   logic [7:0]               scsi_int_enable_first;
   logic [7:0]               scsi_int_enable_second;
   logic [7:0]               control;
   logic [63:0]              shadow_host_address;
   logic                     parity_error_latched;
   logic [3:0]               captured_target_id;
   logic [3:0]               selector_id;
   logic                     single_line_flag;
   logic [9:0]               tick_count;
   logic [1:0]               host_addr_half_select;
   logic                     chip_reset_bit;

   // bus pipeline
   scsi_regs_pkg::bus_state_e bus_state;
   logic                     wr_pending;
   logic [7:0]               wr_index;
   logic [7:0]               rd_index;
   logic                     addr_taken;
   logic [7:0]               addr_index;
   logic [31:0]              next_hrdata;

   // interrupt terms
   logic [7:0]               status_second_gated;
   logic [7:0]               enabled_second;
   logic                     next_interrupt;

   // selection decode
   logic [15:0]              others_lines;
   logic [3:0]               next_selector_id;
   logic [4:0]               line_count;

   assign host_addr_half_select =
      control[scsi_regs_pkg::POS_HALF_SEL +: 2];
   assign chip_reset_bit = control[scsi_regs_pkg::POS_CHIP_RESET];

   ////////////////////////////////////////////////////////////////////////
   // ahb-lite address phase

   // word access only; haddr[1:0] ignored, index is the word address
   assign addr_taken = hsel && hready &&
      (htrans == scsi_regs_pkg::HTRANS_NONSEQ ||
       htrans == scsi_regs_pkg::HTRANS_SEQ);
   assign addr_index = haddr[9:2];

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_pending <= 1'b0;
         wr_index   <= 8'h00;
      end else if (addr_taken && hwrite) begin
         wr_pending <= 1'b1;
         wr_index   <= addr_index;
      end else if (hready) begin
         wr_pending <= 1'b0;
      end
   end

   // reads take one wait state so a write just ahead is already stored
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bus_state <= scsi_regs_pkg::bus_idle;
         rd_index  <= 8'h00;
         hreadyout <= 1'b1;
      end else begin
         case (bus_state)
            scsi_regs_pkg::bus_idle: begin
               if (addr_taken && !hwrite) begin
                  bus_state <= scsi_regs_pkg::bus_read_wait;
                  rd_index  <= addr_index;
                  hreadyout <= 1'b0;
               end
            end
            scsi_regs_pkg::bus_read_wait: begin
               bus_state <= scsi_regs_pkg::bus_idle;
               hreadyout <= 1'b1;
            end
            default: begin
               bus_state <= scsi_regs_pkg::bus_idle;
               hreadyout <= 1'b1;
            end
         endcase
      end
   end

   // only okay answers are given
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hresp <= 1'b0;
      end else begin
         hresp <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // software-written registers

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         scsi_int_enable_first <= scsi_regs_pkg::RST_MASK;
      end else if (wr_pending && hready &&
                   wr_index == scsi_regs_pkg::IDX_INT_EN_FIRST) begin
         scsi_int_enable_first <= hwdata[7:0];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         scsi_int_enable_second <= scsi_regs_pkg::RST_MASK;
      end else if (wr_pending && hready &&
                   wr_index == scsi_regs_pkg::IDX_INT_EN_SECOND) begin
         scsi_int_enable_second <= hwdata[7:0];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         control <= scsi_regs_pkg::RST_CONTROL;
      end else if (wr_pending && hready &&
                   wr_index == scsi_regs_pkg::IDX_CONTROL) begin
         control <= hwdata[7:0];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         own_id_field <= 4'h0;
      end else begin
         own_id_field <= control[3:0];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         scsi_output_data_pair <= scsi_regs_pkg::RST_OUT_DATA;
      end else if (wr_pending && hready) begin
         if (wr_index == scsi_regs_pkg::IDX_OUT_DATA_LOW ||
             wr_index == scsi_regs_pkg::IDX_BUS_LINES_LOW) begin
            scsi_output_data_pair[7:0] <= hwdata[7:0];
         end
         if (wr_index == scsi_regs_pkg::IDX_OUT_DATA_HIGH ||
             wr_index == scsi_regs_pkg::IDX_BUS_LINES_HIGH) begin
            scsi_output_data_pair[15:8] <= hwdata[7:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // shadow host address

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         shadow_host_address <= scsi_regs_pkg::RST_SHADOW;
      end else if (preload_load) begin
         shadow_host_address <= preload_value;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // interrupt

   // latched parity
   // an error in the clearing cycle is kept: set wins
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         parity_error_latched <= 1'b0;
      end else if (scsi_status_second.parity_error_status) begin
         parity_error_latched <= 1'b1;
      end else if (parity_latch_clear) begin
         parity_error_latched <= 1'b0;
      end
   end

   always_comb begin
      status_second_gated = scsi_status_second;
      status_second_gated[scsi_regs_pkg::POS_PARITY] = parity_error_latched;
   end

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_enable
         assign enabled_second[gi] =
            status_second_gated[gi] & scsi_int_enable_second[gi];
      end
   endgenerate

   assign next_interrupt = (|enabled_second) |
      (|(scsi_status_first & scsi_int_enable_first));

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         module_interrupt  <= 1'b0;
         interrupt_a_pin_n <= 1'b1;
      end else begin
         module_interrupt  <= next_interrupt;
         interrupt_a_pin_n <= ~next_interrupt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // software tick

   // one after reset
   // the chip reset bit holds the tick like a reset does
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tick_count    <= 10'h000;
         software_tick <= 1'b1;
      end else if (chip_reset_bit) begin
         tick_count    <= 10'h000;
         software_tick <= 1'b1;
      end else if (tick_count == scsi_regs_pkg::TICK_LAST) begin
         tick_count    <= 10'h000;
         software_tick <= ~software_tick;
      end else begin
         tick_count <= tick_count + 10'h001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // target and selector ids

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         captured_target_id <= 4'h0;
      end else if (chip_reset_bit ||
                   scsi_status_second.bus_free_status) begin
         captured_target_id <= 4'h0;
      end else if (selection_event.claim_bsy) begin
         captured_target_id <= selection_event.claimed_target_id;
      end
   end

   always_comb begin
      others_lines     = scsi_data_lines;
      others_lines[control[3:0]] = 1'b0;
      next_selector_id = 4'h0;
      line_count       = 5'h00;
      for (int i = 0; i < 16; i++) begin
         if (others_lines[i]) begin
            next_selector_id = 4'(i);
         end
         line_count = line_count + 5'(scsi_data_lines[i]);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         selector_id      <= 4'h0;
         single_line_flag <= 1'b0;
      end else if (selection_event.selection_in_sample) begin
         selector_id      <= next_selector_id;
         single_line_flag <= (line_count == 5'h01);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read data

   always_comb begin
      next_hrdata = scsi_regs_pkg::RDATA_ZERO;
      case (rd_index)
         scsi_regs_pkg::IDX_OUT_DATA_LOW:
            next_hrdata[7:0] = scsi_output_data_pair[7:0];
         scsi_regs_pkg::IDX_OUT_DATA_HIGH:
            next_hrdata[7:0] = scsi_output_data_pair[15:8];
         scsi_regs_pkg::IDX_INT_EN_FIRST:
            next_hrdata[7:0] = scsi_int_enable_first;
         scsi_regs_pkg::IDX_INT_EN_SECOND:
            next_hrdata[7:0] = scsi_int_enable_second;
         scsi_regs_pkg::IDX_BUS_LINES_LOW:
            next_hrdata[7:0] = scsi_data_lines[7:0];
         scsi_regs_pkg::IDX_BUS_LINES_HIGH:
            next_hrdata[7:0] = scsi_data_lines[15:8];
         scsi_regs_pkg::IDX_SHADOW_BYTE0,
         scsi_regs_pkg::IDX_SHADOW_BYTE1,
         scsi_regs_pkg::IDX_SHADOW_BYTE2,
         scsi_regs_pkg::IDX_SHADOW_BYTE3: begin
            // no coherence guard while dma runs
            if (host_addr_half_select == scsi_regs_pkg::HALF_LOW) begin
               next_hrdata[7:0] =
                  shadow_host_address[{rd_index[1:0], 3'b000} +: 8];
            end else if (host_addr_half_select ==
                         scsi_regs_pkg::HALF_HIGH) begin
               next_hrdata[7:0] =
                  shadow_host_address[{1'b1, rd_index[1:0], 3'b000} +: 8];
            end
         end
         scsi_regs_pkg::IDX_TARGET_TICK: begin
            next_hrdata[scsi_regs_pkg::POS_TICK] = software_tick;
            next_hrdata[3:0] = captured_target_id;
         end
         scsi_regs_pkg::IDX_SELECTOR_ID: begin
            next_hrdata[7:4] = selector_id;
            next_hrdata[scsi_regs_pkg::POS_SINGLE_LINE] = single_line_flag;
         end
         scsi_regs_pkg::IDX_CONTROL:
            next_hrdata[7:0] = control;
         default:
            next_hrdata = scsi_regs_pkg::RDATA_ZERO;
      endcase
   end

   // sampled once in the wait cycle; lines are live at that edge only
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hrdata <= scsi_regs_pkg::RDATA_ZERO;
      end else if (bus_state == scsi_regs_pkg::bus_read_wait) begin
         hrdata <= next_hrdata;
      end
   end

endmodule : scsi_intmask_bus_shadow_id_regs

// >>> hw/scsi_regs_pkg.sv
// constants, field layouts and carrier types for the scsi register bank
package scsi_regs_pkg;

   ////////////////////////////////////////////////////////////////////////
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_OUT_DATA_LOW   = 8'h06;
   localparam logic [7:0] IDX_OUT_DATA_HIGH  = 8'h07;
   localparam logic [7:0] IDX_INT_EN_FIRST   = 8'h10;
   localparam logic [7:0] IDX_INT_EN_SECOND  = 8'h11;
   localparam logic [7:0] IDX_BUS_LINES_LOW  = 8'h12;
   localparam logic [7:0] IDX_BUS_LINES_HIGH = 8'h13;
   localparam logic [7:0] IDX_SHADOW_BYTE0   = 8'h14;
   localparam logic [7:0] IDX_SHADOW_BYTE1   = 8'h15;
   localparam logic [7:0] IDX_SHADOW_BYTE2   = 8'h16;
   localparam logic [7:0] IDX_SHADOW_BYTE3   = 8'h17;
   localparam logic [7:0] IDX_TARGET_TICK    = 8'h18;
   localparam logic [7:0] IDX_SELECTOR_ID    = 8'h19;
   localparam logic [7:0] IDX_CONTROL        = 8'h1C;

   ////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int POS_TICK        = 7;
   localparam int POS_SINGLE_LINE = 3;
   localparam int POS_HALF_SEL    = 4;
   localparam int POS_CHIP_RESET  = 7;
   localparam int POS_PARITY      = 2;

   // host address half select encodings
   localparam logic [1:0] HALF_LOW  = 2'h0;
   localparam logic [1:0] HALF_HIGH = 2'h1;

   // reset values
   localparam logic [7:0]  RST_MASK     = 8'h00;
   localparam logic [7:0]  RST_CONTROL  = 8'h00;
   localparam logic [15:0] RST_OUT_DATA = 16'h0000;
   localparam logic [63:0] RST_SHADOW   = 64'h0000_0000_0000_0000;
   localparam logic [31:0] RDATA_ZERO   = 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////
   // timing: clock 100 ns, tick period 102.40 us, hold after reset 51.2 us
   localparam int CLK_PERIOD_NS  = 100;
   localparam int TICK_PERIOD_NS = 102400;
   localparam int TICK_HOLD_NS   = 51200;
   localparam int TICK_HALF_CYC  = (TICK_PERIOD_NS / 2) / CLK_PERIOD_NS;
   localparam int TICK_HOLD_CYC  = TICK_HOLD_NS / CLK_PERIOD_NS;
   localparam logic [9:0] TICK_LAST = 10'(TICK_HALF_CYC - 1);

   ////////////////////////////////////////////////////////////////////////
   // htrans encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ    = 2'h3;

   // second group of scsi events, msb first as in the enable register
   typedef struct packed {
      logic select_timeout_status;
      logic attention_as_target_status;
      logic bus_reset_status;
      logic phase_mismatch_status;
      logic bus_free_status;
      logic parity_error_status;
      logic phase_change_status;
      logic request_initiator_status;
   } scsi_status_second_s;

   // selection events seen on the scsi bus
   typedef struct packed {
      logic       claim_bsy;
      logic [3:0] claimed_target_id;
      logic       selection_in_sample;
   } selection_event_s;

   typedef enum logic {bus_idle, bus_read_wait} bus_state_e;

endpackage : scsi_regs_pkg

// >>> test/scsi_regs_sva.sv
// port checker for the scsi register bank
module scsi_regs_sva (
   // clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // register bus
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   // scsi side
   input wire logic [15:0] scsi_data_lines,
   input wire logic [15:0] scsi_output_data_pair,
   input wire logic        module_interrupt,
   input wire logic        interrupt_a_pin_n,
   input wire logic        software_tick
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic       taken;
   logic       tick_q;
   logic [9:0] run;
   logic       wr_ctl;
   logic       chip_hold;
   assign taken = hsel && hready && htrans[1];
   ////////////////////////////////////////////////////////////////////////
   // a control write with bit 7 set holds the tick just as reset does
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_ctl    <= 1'b0;
         chip_hold <= 1'b0;
      end else begin
         if (hready) begin
            wr_ctl <= taken && hwrite &&
               haddr[9:2] == scsi_regs_pkg::IDX_CONTROL;
         end
         if (wr_ctl && hready) begin
            chip_hold <= hwdata[scsi_regs_pkg::POS_CHIP_RESET];
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // run counts edges the tick has stood since its last change or hold
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tick_q <= 1'b1;
         run    <= 10'h000;
      end else begin
         tick_q <= software_tick;
         run    <= chip_hold ? 10'h000 :
                   (software_tick != tick_q) ? 10'h001 : run + 10'h001;
      end
   end
   sequence rd_any; taken && !hwrite; endsequence
   sequence wr_any; taken && hwrite; endsequence
   sequence rd_lo;
      rd_any ##0 haddr[9:2] == scsi_regs_pkg::IDX_BUS_LINES_LOW;
   endsequence
   sequence wr_lo;
      wr_any ##0 haddr[9:2] == scsi_regs_pkg::IDX_BUS_LINES_LOW;
   endsequence
   ////////////////////////////////////////////////////////////////////////
   pin_inverse_a:
      assert property (interrupt_a_pin_n == !module_interrupt)
      else $error("interrupt pin not inverse of interrupt");
   okay_resp_a:
      assert property (hresp == 1'b0)
      else $error("response not okay");
   read_wait_a:
      assert property (rd_any |=> !hreadyout ##1 hreadyout)
      else $error("read wait cycle wrong");
   write_ready_a:
      assert property (wr_any |=> hreadyout)
      else $error("write not zero wait");
   bus_live_a:
      assert property (rd_lo ##1 1'b1 |=>
         hrdata[7:0] == $past(scsi_data_lines[7:0]))
      else $error("bus line read not live");
   pair_write_a:
      assert property (wr_lo ##1 1'b1 |=>
         scsi_output_data_pair[7:0] == $past(hwdata[7:0]))
      else $error("bus line write not in output pair");
   upper_zero_a:
      assert property ($rose(hreadyout) |-> hrdata[31:8] == 24'h00_0000)
      else $error("upper read bits not zero");
   tick_period_a:
      assert property ((software_tick != tick_q) && !chip_hold |->
         run == 10'h200)
      else $error("tick half period wrong");
   tick_hold_a:
      assert property (@(posedge clk) disable iff (1'b0)
         rst && $past(rst) |-> software_tick)
      else $error("tick not one in reset");
endmodule : scsi_regs_sva

bind scsi_intmask_bus_shadow_id_regs scsi_regs_sva chk (
   .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp),
   .scsi_data_lines(scsi_data_lines),
   .scsi_output_data_pair(scsi_output_data_pair),
   .module_interrupt(module_interrupt),
   .interrupt_a_pin_n(interrupt_a_pin_n), .software_tick(software_tick)
);

// >>> test/scsi_bus_model.sv
// model of the scsi devices that drive the data lines and selections
module scsi_bus_model (
   // clock
   input  wire logic                       clk,
   // requests from the bench
   input  wire logic                       drive,
   input  wire logic [15:0]                lines,
   input  wire logic                       sel_go,
   input  wire logic                       claim_go,
   input  wire logic [3:0]                 claim_id,
   // bus side
   output logic [15:0]                     scsi_data_lines,
   output scsi_regs_pkg::selection_event_s selection_event
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      scsi_data_lines = 16'h0000;
      selection_event = '0;
   end
   // released lines fall to the terminated deasserted level
   always @(posedge clk) begin
      scsi_data_lines <= drive ? lines : 16'h0000;
   end
   always @(posedge clk) begin
      selection_event <= {claim_go, claim_id, sel_go};
   end
endmodule : scsi_bus_model

// >>> test/scsi_intmask_bus_shadow_id_regs_bench.sv
// self-checking bench for the scsi register bank
module scsi_intmask_bus_shadow_id_regs_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk, rst, hsel, hwrite, hready, hreadyout, hresp;
   logic        parity_latch_clear, preload_load, drive, sel_go, claim_go;
   logic        module_interrupt, interrupt_a_pin_n, software_tick;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [15:0] lines, scsi_data_lines, scsi_output_data_pair;
   logic [7:0]  scsi_status_first, q;
   logic [3:0]  claim_id, own_id_field;
   logic [63:0] preload_value;
   int          n_mismatch, comparisons;
   scsi_regs_pkg::scsi_status_second_s scsi_status_second;
   scsi_regs_pkg::selection_event_s    selection_event;
   assign hready = hreadyout;
   scsi_intmask_bus_shadow_id_regs dut (
      .clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready, .hrdata, .hreadyout, .hresp, .scsi_data_lines,
      .scsi_status_first, .scsi_status_second, .parity_latch_clear,
      .selection_event, .preload_load, .preload_value,
      .scsi_output_data_pair, .own_id_field, .module_interrupt,
      .interrupt_a_pin_n, .software_tick);
   scsi_bus_model bus_model (
      .clk, .drive, .lines, .sel_go, .claim_go, .claim_id,
      .scsi_data_lines, .selection_event);
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   task automatic ahb(input logic w, input logic [7:0] idx,
                      input logic [7:0] d);
      @(posedge clk);
      hsel   <= 1'b1;
      htrans <= scsi_regs_pkg::HTRANS_NONSEQ;
      haddr  <= {22'h00_0000, idx, 2'h0};
      hwrite <= w;
      hsize  <= 3'h2;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h00_0000, d};
      do @(posedge clk); while (hreadyout !== 1'b1);
      q = hrdata[7:0];
   endtask : ahb
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      ahb(1'b1, idx, d);
   endtask : wr
   task automatic chk(input string name, input logic [15:0] exp, got);
      comparisons++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", name, exp, got);
         n_mismatch++;
      end
   endtask : chk
   task automatic rdchk(input string name, input logic [7:0] idx, exp);
      ahb(1'b0, idx, 8'h00);
      chk(name, exp, q);
   endtask : rdchk
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      rdchk("second mask", 8'h11, 8'h00);
      rdchk("target and tick", 8'h18, 8'h80);
      rdchk("selector id", 8'h19, 8'h00);
      chk("interrupt pin", 1'b1, interrupt_a_pin_n);
      $display("test reset done");
   endtask : t_reset
   task automatic t_mask;
      for (int i = 0; i < 8; i++) begin
         wr(8'h11, 8'(1 << i));
         rdchk("second mask", 8'h11, 8'(1 << i));
         scsi_status_second[i] <= 1'b1;
         cyc(3);
         chk("interrupt on", 1'b1, module_interrupt);
         scsi_status_second[i] <= 1'b0;
         cyc(3);
         chk("interrupt latched", i == 2, module_interrupt);
         parity_latch_clear <= 1'b1;
         cyc(1);
         parity_latch_clear <= 1'b0;
         cyc(3);
         chk("interrupt cleared", 1'b0, module_interrupt);
      end
      scsi_status_second <= 8'h7f;
      scsi_status_first  <= 8'hff;
      cyc(3);
      chk("interrupt masked", 1'b0, module_interrupt);
      wr(8'h10, 8'h01);
      cyc(3);
      chk("first group", 1'b1, module_interrupt);
      scsi_status_first <= 8'h00;
      wr(8'h11, 8'h00);
      parity_latch_clear <= 1'b1;
      cyc(1);
      parity_latch_clear <= 1'b0;
      scsi_status_second <= 8'h00;
      cyc(3);
      chk("interrupt off", 1'b0, module_interrupt);
      $display("test mask done");
   endtask : t_mask
   task automatic t_bus;
      lines <= 16'ha55a;
      drive <= 1'b1;
      cyc(2);
      rdchk("bus low", 8'h12, 8'h5a);
      rdchk("bus high", 8'h13, 8'ha5);
      lines <= 16'h0ff0;
      cyc(2);
      rdchk("bus low again", 8'h12, 8'hf0);
      wr(8'h12, 8'h3c);
      wr(8'h13, 8'hc3);
      cyc(1);
      chk("output pair", 16'hc33c, scsi_output_data_pair);
      rdchk("pair low", 8'h06, 8'h3c);
      rdchk("pair high", 8'h07, 8'hc3);
      rdchk("bus low live", 8'h12, 8'hf0);
      drive <= 1'b0;
      $display("test bus done");
   endtask : t_bus
   task automatic t_shadow;
      preload_value <= 64'h0123_4567_89ab_cdef;
      preload_load  <= 1'b1;
      cyc(1);
      preload_load  <= 1'b0;
      // reads only while dma is idle
      wr(8'h14, 8'h55);
      wr(8'h17, 8'haa);
      for (int h = 0; h < 2; h++) begin
         wr(8'h1c, 8'(h << 4));
         for (int b = 0; b < 4; b++) begin
            rdchk("shadow", 8'(8'h14 + b),
                  preload_value[8 * (4 * h + b) +: 8]);
         end
      end
      wr(8'h1c, 8'h20);
      rdchk("shadow unused half", 8'h14, 8'h00);
      $display("test shadow done");
   endtask : t_shadow
   task automatic select(input logic [15:0] v);
      lines  <= v;
      drive  <= 1'b1;
      sel_go <= 1'b1;
      cyc(1);
      sel_go <= 1'b0;
      drive  <= 1'b0;
   endtask : select
   task automatic t_select;
      wr(8'h1c, 8'h05);
      cyc(2);
      chk("own id", 4'h5, own_id_field);
      select(16'h0028);
      rdchk("selector two lines", 8'h19, 8'h30);
      select(16'h0200);
      rdchk("selector one line", 8'h19, 8'h98);
      claim_id <= 4'hb;
      claim_go <= 1'b1;
      cyc(1);
      claim_go <= 1'b0;
      ahb(1'b0, 8'h18, 8'h00);
      chk("target id", 8'h0b, q & 8'h7f);
      scsi_status_second.bus_free_status <= 1'b1;
      cyc(1);
      scsi_status_second.bus_free_status <= 1'b0;
      ahb(1'b0, 8'h18, 8'h00);
      chk("target id freed", 8'h00, q & 8'h7f);
      claim_go <= 1'b1;
      cyc(1);
      claim_go <= 1'b0;
      wr(8'h1c, 8'h85);
      rdchk("chip reset held", 8'h18, 8'h80);
      wr(8'h1c, 8'h05);
      $display("test select done");
   endtask : t_select
   task automatic t_tick;
      int n;
      n = 0;
      while (software_tick !== 1'b0 && n < 1100) begin
         cyc(1);
         n++;
      end
      n = 0;
      while (software_tick === 1'b0 && n < 1100) begin
         cyc(1);
         n++;
      end
      chk("tick low span", 16'h0200, 16'(n));
      $display("test tick done");
   endtask : t_tick
   ////////////////////////////////////////////////////////////////////////
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : conclude
   initial begin
      #1_000_000;
      n_mismatch++;
      conclude();
   end
   initial begin
      rst = 1'b1;
      {hsel, hwrite, parity_latch_clear, preload_load} = 4'h0;
      {drive, sel_go, claim_go} = 3'h0;
      haddr = 32'h0000_0000;
      hwdata = 32'h0000_0000;
      htrans = 2'h0;
      hsize = 3'h2;
      lines = 16'h0000;
      scsi_status_first = 8'h00;
      scsi_status_second = 8'h00;
      claim_id = 4'h0;
      preload_value = 64'h0000_0000_0000_0000;
      n_mismatch = 0;
      comparisons = 0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_mask();
      t_bus();
      t_shadow();
      t_select();
      t_tick();
      conclude();
   end
endmodule : scsi_intmask_bus_shadow_id_regs_bench
